/* timebase_pkg.sv */
// constants for the eeprom timebase divider
package timebase_pkg;
    // ----------------------------------------
    // register map (word offsets as byte addresses)
    // ----------------------------------------
    localparam logic [4:0] off_divisor_low_reg = 5'h00;
    localparam logic [4:0] off_divisor_high_reg = 5'h04;
    localparam logic [4:0] off_divisor_low_shadow = 5'h08;
    localparam logic [4:0] off_divisor_high_shadow = 5'h0c;
    localparam logic [4:0] off_control = 5'h10;
    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int lock_disable_bit = 7;
    localparam int divisor_width = 11;
    localparam int high_bits = 3;
    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int ctl_ref_select_bit = 0;
    localparam int ctl_latch_bit = 1;
    localparam int ctl_proposed_bit = 2;
    localparam int ctl_shadow_prog_bit = 3;
    // ----------------------------------------
    // values after reset and timing
    // ----------------------------------------
    localparam logic [7:0] erased_byte = 8'hff;
    localparam int timebase_period_us = 35;
    localparam int ref_clk_khz = 10000;
    localparam int timebase_cycles = (ref_clk_khz * timebase_period_us + 500) / 1000;
endpackage

/* tick_if.sv */
// interface between divider core and register front end
`timescale 1ns/1ps
`default_nettype none
interface tick_if #(parameter int W = 11);
    logic [W-1:0] divisor;
    logic ref_enable;
    logic tick;
    modport ctrl (output divisor, output ref_enable, input tick);
    modport core (input divisor, input ref_enable, output tick);
endinterface
`default_nettype wire

/* timebase_counter.sv */
// divider core counting reference cycles
`timescale 1ns/1ps
`default_nettype none
module timebase_counter #(
    parameter int W = 11
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    tick_if.core port
);
    logic [W-1:0] count;
    logic tick_q;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            count <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (port.ref_enable) begin
                if (port.divisor != '0 && count >= port.divisor - W'(1)) begin
                    count <= '0;
                    tick_q <= 1'b1;
                end else begin
                    count <= count + W'(1);
                end
            end
        end
    end
    assign port.tick = tick_q;

    a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        tick_q |=> !tick_q || ($past(port.divisor) == W'(1))) else $error("ticks too close");
    a_no_zero_tick: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (port.divisor == '0) |=> !tick_q) else $error("tick with zero divisor");
    a_tick_enable: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        tick_q |-> $past(port.ref_enable)) else $error("tick without reference cycle");
endmodule
`default_nettype wire

/* timebase_divider.sv */
// eeprom timebase divider with shadow load and lock
// Summary of operation
// - emit a timebase tick whose period is 35 us of reference clock
// - reference is crystal clock or bus clock, chosen by a select bit
// - divisor is 11 bits split over high and low registers
// - stored divisor is the division ratio directly
// - divisor bits read back at any time
// - divisor writes only with latch clear and lock disable set
// - lock disable reads 1 when off; when on both registers are locked
// - while locked the shadow registers refuse program and erase
// - reset copies shadow divisor and lock disable into volatile registers
// - shadows keep contents across reset
// - new shadow values reach volatile registers only at next reset
// - shadow lock bit 0 makes the lock permanent after reset
// - shadow bits hold programmed value, erased reads 1
// - while proposed mode is set, writes to divider registers do nothing
`timescale 1ns/1ps
`default_nettype none
module timebase_divider #(
    parameter int W = timebase_pkg::divisor_width
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_crystal_ref_clock,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_timebase_tick
);
    tick_if #(.W(W)) link ();

    logic [7:0] divisor_low_reg;
    logic [7:0] divisor_high_reg;
    logic [7:0] divisor_low_shadow = timebase_pkg::erased_byte;
    logic [7:0] divisor_high_shadow = timebase_pkg::erased_byte;
    logic divisor_ref_select;
    logic array_latch_enable;
    logic proposed_mode;
    logic shadow_program;
    logic [3:0] control;
    logic loaded;
    logic xtal_sync1;
    logic xtal_sync2;
    logic xtal_last;
    logic answered;
    logic [31:0] next_readdata;
    logic wr_hit;
    logic [3:0] wr_addr;
    logic divisor_writable;
    logic shadow_writable;
    logic locked;

    // ----------------------------------------
    // pin synchroniser for crystal reference
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            xtal_sync1 <= 1'b0;
            xtal_sync2 <= 1'b0;
            xtal_last <= 1'b0;
        end else begin
            xtal_sync1 <= i_crystal_ref_clock;
            xtal_sync2 <= xtal_sync1;
            xtal_last <= xtal_sync2;
        end
    end

    // reference enable: crystal edge or every bus cycle
    assign link.ref_enable = divisor_ref_select ? 1'b1 : (xtal_sync2 & ~xtal_last);
    assign link.divisor = {divisor_high_reg[timebase_pkg::high_bits-1:0], divisor_low_reg};
    assign o_timebase_tick = link.tick;

    timebase_counter #(.W(W)) u_counter (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .port(link)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign wr_addr = i_avs_address[4:1];
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~answered;
    assign wr_hit = i_avs_write & answered & i_avs_byteenable[0];
    assign locked = ~divisor_high_reg[timebase_pkg::lock_disable_bit];
    assign divisor_writable = ~array_latch_enable & ~locked & ~proposed_mode;
    assign shadow_writable = ~locked & shadow_program & ~proposed_mode;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            answered <= 1'b0;
        end else begin
            answered <= (i_avs_read | i_avs_write) & ~answered;
        end
    end

    // ----------------------------------------
    // volatile divider registers
    // ----------------------------------------
    // after async reset a clocked load copies the shadows
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            loaded <= 1'b0;
            divisor_low_reg <= 8'h00;
            divisor_high_reg <= 8'h00;
        end else if (!loaded) begin
            loaded <= 1'b1;
            divisor_low_reg <= divisor_low_shadow;
            divisor_high_reg <= divisor_high_shadow & 8'h87;
        end else if (wr_hit && divisor_writable) begin
            if (wr_addr == timebase_pkg::off_divisor_low_reg[4:1]) begin
                divisor_low_reg <= i_avs_writedata[7:0];
            end else if (wr_addr == timebase_pkg::off_divisor_high_reg[4:1]) begin
                divisor_high_reg <= i_avs_writedata[7:0] & 8'h87;
            end
        end
    end

    // ----------------------------------------
    // shadow registers, no reset term
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset && loaded && wr_hit && shadow_writable) begin
            if (wr_addr == timebase_pkg::off_divisor_low_shadow[4:1]) begin
                divisor_low_shadow <= i_avs_writedata[7:0];
            end else if (wr_addr == timebase_pkg::off_divisor_high_shadow[4:1]) begin
                divisor_high_shadow <= i_avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            divisor_ref_select <= 1'b0;
            array_latch_enable <= 1'b0;
            proposed_mode <= 1'b0;
            shadow_program <= 1'b0;
        end else if (wr_hit && wr_addr == timebase_pkg::off_control[4:1]) begin
            divisor_ref_select <= i_avs_writedata[timebase_pkg::ctl_ref_select_bit];
            array_latch_enable <= i_avs_writedata[timebase_pkg::ctl_latch_bit];
            proposed_mode <= i_avs_writedata[timebase_pkg::ctl_proposed_bit];
            shadow_program <= i_avs_writedata[timebase_pkg::ctl_shadow_prog_bit];
        end
    end
    assign control = {shadow_program, proposed_mode, array_latch_enable, divisor_ref_select};

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (wr_addr == timebase_pkg::off_divisor_low_reg[4:1]) begin
            next_readdata[7:0] = divisor_low_reg;
        end else if (wr_addr == timebase_pkg::off_divisor_high_reg[4:1]) begin
            next_readdata[7:0] = divisor_high_reg;
        end else if (wr_addr == timebase_pkg::off_divisor_low_shadow[4:1]) begin
            next_readdata[7:0] = divisor_low_shadow;
        end else if (wr_addr == timebase_pkg::off_divisor_high_shadow[4:1]) begin
            next_readdata[7:0] = divisor_high_shadow;
        end else if (wr_addr == timebase_pkg::off_control[4:1]) begin
            next_readdata[3:0] = control;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !answered) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_low_write;
        loaded && wr_hit && divisor_writable && (wr_addr == timebase_pkg::off_divisor_low_reg[4:1]);
    endsequence
    sequence s_high_write;
        loaded && wr_hit && divisor_writable && (wr_addr == timebase_pkg::off_divisor_high_reg[4:1]);
    endsequence
    sequence s_low_read;
        i_avs_read && !answered && (wr_addr == timebase_pkg::off_divisor_low_reg[4:1]);
    endsequence

    a_lock_holds: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (loaded && locked) |=> $stable(link.divisor) && locked) else $error("locked divisor changed");
    a_latch_blocks: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (loaded && array_latch_enable) |=> $stable(divisor_low_reg)) else $error("write under latch");
    a_shadow_locked: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (loaded && locked) |=> $stable(divisor_low_shadow) && $stable(divisor_high_shadow))
        else $error("shadow changed while locked");
    a_reset_load: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !loaded |=> divisor_low_reg == $past(divisor_low_shadow)) else $error("shadow not loaded");
    a_high_load: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !loaded |=> divisor_high_reg == ($past(divisor_high_shadow) & 8'h87)) else $error("high shadow not loaded");
    a_shadow_reset: assert property (@(posedge i_ref_clk)
        i_reset |=> $stable(divisor_low_shadow) && $stable(divisor_high_shadow)) else $error("reset touched shadow");
    a_proposed_ignore: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (loaded && proposed_mode) |=> $stable(divisor_high_reg)) else $error("write in proposed mode");
    a_low_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_low_write |=> {24'h000000, divisor_low_reg} == ($past(i_avs_writedata) & 32'h0000_00ff))
        else $error("low divisor write lost");
    a_high_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_high_write |=> {24'h000000, divisor_high_reg} == ($past(i_avs_writedata) & 32'h0000_0087))
        else $error("high divisor write lost");
    a_low_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_low_read |=> o_avs_readdata[7:0] == $past(divisor_low_reg)) else $error("low divisor read wrong");
    a_read_upper: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_avs_readdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_wait_one: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_avs_read && !answered) |=> !o_avs_waitrequest) else $error("no answer");
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the eeprom timebase divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // clock, stimulus and counters
    // ----------------------------------------
    localparam logic [4:0] a_lo = 5'h00, a_hi = 5'h04, a_slo = 5'h08, a_shi = 5'h0c, a_ctl = 5'h10;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [4:0] i_avs_address = 5'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic o_timebase_tick;
    logic [3:0] xcnt = 4'h0;
    logic [31:0] seed = 32'h57ff;
    logic [31:0] q;
    logic [10:0] d;
    logic [7:0] b;
    int n_mismatch = 0;
    int checked = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    // crystal reference rises every fourth bus cycle
    always @(posedge i_ref_clk) xcnt <= xcnt + 4'h1;
    timebase_divider timebase_divider_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_crystal_ref_clock(xcnt[1]), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_timebase_tick(o_timebase_tick));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [7:0] hi_byte(input logic [10:0] v);
        return {1'b1, 4'h0, v[10:8]};
    endfunction
    function automatic int period(input logic [10:0] v, input logic bus_ref);
        return bus_ref ? int'(v) : 4 * int'(v);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v, input logic [3:0] be,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, v};
        i_avs_byteenable <= be;
        i_avs_read <= ~wr;
        i_avs_write <= wr;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(32'h1, 32'h0);
        r = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic [31:0] r;
        bus(1'b1, a, v, 4'hf, r);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, 4'hf, r);
        check(r, {24'h0, e});
    endtask
    task automatic set_div(input logic [10:0] v);
        wr(a_lo, v[7:0]);
        wr(a_hi, hi_byte(v));
    endtask
    task automatic do_reset();
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask
    task automatic measure(input int exp);
        int n;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_timebase_tick !== 1'b1 && n < 3000);
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_timebase_tick !== 1'b1 && n < 3000);
        check(32'(n), 32'(exp));
    endtask
    task automatic summarize();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(100 * 60000);
        n_mismatch++;
        summarize();
    end
    initial begin
        do_reset();
        rd_chk(a_lo, 8'hff);
        rd_chk(a_hi, 8'h87);
        rd_chk(a_shi, 8'hff);
        rd_chk(a_slo, 8'hff);
        rd_chk(a_ctl, 8'h00);
        rd_chk(5'h14, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            d = 11'(rnd());
            set_div(d);
            rd_chk(a_lo, d[7:0]);
            rd_chk(a_hi, hi_byte(d));
        end
        $display("test divisor readback done");
        wr(a_ctl, 8'h01);
        rd_chk(a_ctl, 8'h01);
        for (int i = 0; i < 3; i++) begin
            d = 11'(2 + rnd() % 6);
            set_div(d);
            measure(period(d, 1'b1));
        end
        set_div(11'(timebase_pkg::timebase_cycles));
        measure(350);
        wr(a_ctl, 8'h00);
        set_div(11'h003);
        measure(period(11'h003, 1'b0));
        set_div(11'h005);
        measure(period(11'h005, 1'b0));
        $display("test tick period done");
        b = 8'(rnd()) | 8'h80;
        wr(a_ctl, 8'h02);
        wr(a_lo, b);
        rd_chk(a_lo, 8'h05);
        wr(a_ctl, 8'h04);
        wr(a_lo, b);
        rd_chk(a_lo, 8'h05);
        wr(a_ctl, 8'h00);
        bus(1'b1, a_lo, b, 4'he, q);
        rd_chk(a_lo, 8'h05);
        $display("test refused writes done");
        wr(a_ctl, 8'h08);
        wr(a_slo, b);
        wr(a_shi, 8'h03);
        rd_chk(a_slo, b);
        rd_chk(a_lo, 8'h05);
        do_reset();
        rd_chk(a_lo, b);
        rd_chk(a_hi, 8'h03);
        rd_chk(a_shi, 8'h03);
        wr(a_lo, ~b);
        wr(a_hi, 8'h87);
        rd_chk(a_lo, b);
        rd_chk(a_hi, 8'h03);
        wr(a_ctl, 8'h08);
        wr(a_slo, ~b);
        rd_chk(a_slo, b);
        do_reset();
        rd_chk(a_hi, 8'h03);
        $display("test shadow and lock done");
        summarize();
    end
endmodule
`default_nettype wire
